// >>> fpsic_top.sv
// front panel status indicator control: power, fault, drive, network leds and switches
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module fpsic_top #(
    parameter int unsigned SLOW_HALF = int'(fpsic_pkg::SLOW_HALF_CYC),
    parameter int unsigned FAST_HALF = int'(fpsic_pkg::FAST_HALF_CYC),
    parameter int unsigned POWER_ON_SELF_TEST_LEN  = int'(fpsic_pkg::POWER_ON_SELF_TEST_CYC),
    parameter int unsigned DEB_LEN   = int'(fpsic_pkg::DEBOUNCE_CYC),
    parameter int unsigned PG_WAIT   = int'(fpsic_pkg::PG_WAIT_CYC)
) (
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  wire fpsic_pkg::fpsic_bus_t            bus,
    output logic [fpsic_pkg::DATA_W-1:0]          rdata,
    input  wire fpsic_pkg::fpsic_pins_t           pins,
    output logic                                  supply_on_request,
    output logic                                  system_reset_n,
    output logic                                  power_led_n,
    output logic                                  system_fault_indicator_n,
    output logic                                  network_led_n,
    output logic [fpsic_pkg::NUM_DRIVES-1:0]      drive_fault_led_n,
    output logic [fpsic_pkg::NUM_DRIVES-1:0]      drive_activity_led_n,
    output fpsic_pkg::fpsic_oc_t                  switch_oc,
    output logic                                  power_good_change,
    output logic                                  sleep_request,
    output logic                                  reset_request
);

    localparam int unsigned ND = fpsic_pkg::NUM_DRIVES;
    localparam int unsigned NS = fpsic_pkg::NUM_SW;
    localparam int unsigned CW = fpsic_pkg::CNT_W;

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    fpsic_pkg::fpsic_pins_t pin_meta;    // first stage, read only by the second
    fpsic_pkg::fpsic_pins_t pin_s;       // synchronised pins

    // two flops on every pin before any logic sees it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '{sw_n: '1, default: '0}; // switches idle, no false press
            pin_s    <= '{sw_n: '1, default: '0};
        end else begin
            pin_meta <= pins;
            pin_s    <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // blink dividers
    logic [CW-1:0] slow_cnt;             // slow half period counter
    logic [CW-1:0] fast_cnt;             // fast half period counter
    logic          slow_ph;              // slow blink phase, high is lit
    logic          fast_ph;              // fast blink phase, high is lit
    logic          fast_wrap;            // end of a fast half period

    assign fast_wrap = (fast_cnt == CW'(FAST_HALF - 1));

    // free running dividers give equal on and off halves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_cnt <= '0;
            slow_ph  <= 1'b0;
        end else if (slow_cnt == CW'(SLOW_HALF - 1)) begin
            slow_cnt <= '0;
            slow_ph  <= ~slow_ph;
        end else begin
            slow_cnt <= slow_cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_cnt <= '0;
            fast_ph  <= 1'b0;
        end else if (fast_wrap) begin
            fast_cnt <= '0;
            fast_ph  <= ~fast_ph;
        end else begin
            fast_cnt <= fast_cnt + CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // switch debounce
    logic [NS-1:0] sw_db;                // debounced pressed level
    logic [NS-1:0] sw_press;             // one cycle per accepted press

    // a bounce restarts the stability count, so only a settled level is taken
    for (genvar i = 0; i < NS; i++) begin : g_sw
        logic [CW-1:0] deb_cnt;          // cycles the raw level has differed
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                deb_cnt     <= '0;
                sw_db[i]    <= 1'b0;
                sw_press[i] <= 1'b0;
            end else begin
                sw_press[i] <= 1'b0;
                if (~pin_s.sw_n[i] == sw_db[i]) begin
                    deb_cnt <= '0;
                end else if (deb_cnt == CW'(DEB_LEN - 1)) begin
                    deb_cnt     <= '0;
                    sw_db[i]    <= ~pin_s.sw_n[i];
                    sw_press[i] <= ~pin_s.sw_n[i];
                end else begin
                    deb_cnt <= deb_cnt + CW'(1);
                end
            end
        end
    end

    // lines toward the board only ever pull low; enable follows the press
    assign switch_oc.out = '0;
    assign switch_oc.oe  = sw_db;

    ////////////////////////////////////////////////////////////////////////////////
    // register write side
    logic                      wr_ctrl;      // write to control
    logic                      wr_drive;     // write to drive flags
    logic                      wr_event;     // write to events
    fpsic_pkg::fpsic_pstate_t  pstate;       // system power state from software
    logic                      fan_fail;     // fan failure from software
    logic [ND-1:0]             drive_fail;   // drive failure flags
    logic [fpsic_pkg::EVT_W-1:0] events;     // sticky events
    logic [fpsic_pkg::EVT_W-1:0] evt_set;    // event sources this cycle

    assign wr_ctrl  = bus.wr && (bus.addr == fpsic_pkg::OFS_CTRL);
    assign wr_drive = bus.wr && (bus.addr == fpsic_pkg::OFS_DRIVE);
    assign wr_event = bus.wr && (bus.addr == fpsic_pkg::OFS_EVENT);

    // control fields steer the led and fault logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pstate   <= fpsic_pkg::FPSIC_PS_OFF;
            fan_fail <= 1'b0;
        end else if (wr_ctrl) begin
            pstate   <= fpsic_pkg::fpsic_pstate_t'(bus.wdata[fpsic_pkg::CTRL_STATE_LSB +: 2]);
            fan_fail <= bus.wdata[fpsic_pkg::CTRL_FAN_FAIL];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_fail <= '0;
        end else if (wr_drive) begin
            drive_fail <= bus.wdata[ND-1:0];
        end
    end

    // supply request: a press toggles it; a same cycle software write is overridden
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_on_request <= 1'b0;
        end else if (sw_press[fpsic_pkg::SW_POWER]) begin
            supply_on_request <= ~supply_on_request;
        end else if (wr_ctrl) begin
            supply_on_request <= bus.wdata[fpsic_pkg::CTRL_SUPPLY_ON];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // supply supervision
    logic          pg_d;                 // power good one cycle back
    logic          supply_fault;         // request without power good too long
    logic [CW-1:0] pg_wait_cnt;          // cycles spent waiting for power good
    logic          mismatch;             // commanded state differs from supply

    assign mismatch = supply_on_request ^ pin_s.power_good;

    // change detector on the synchronised power good
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_d              <= 1'b0;
            power_good_change <= 1'b0;
        end else begin
            pg_d              <= pin_s.power_good;
            power_good_change <= pin_s.power_good ^ pg_d;
        end
    end

    // fault sets after the grace time and clears the cycle power good shows
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_wait_cnt  <= '0;
            supply_fault <= 1'b0;
        end else if (!supply_on_request || pin_s.power_good) begin
            pg_wait_cnt  <= '0;
            supply_fault <= 1'b0;
        end else if (pg_wait_cnt == CW'(PG_WAIT - 1)) begin
            supply_fault <= 1'b1;
        end else begin
            pg_wait_cnt <= pg_wait_cnt + CW'(1);
        end
    end

    // reset held while power is missing, so a sudden loss resets at once;
    // release waits one cycle behind the fault clear so the order holds
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            system_reset_n <= 1'b0;
        end else begin
            system_reset_n <= supply_on_request && pin_s.power_good && !supply_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power led pattern
    fpsic_pkg::fpsic_led_t pled;         // selected pattern
    logic                  pled_lit;     // pattern output before inversion

    // standby loss or request low wins over every other input
    always_comb begin
        pled = fpsic_pkg::FPSIC_LED_OFF;
        if (pin_s.standby && supply_on_request) begin
            case (pstate)
                fpsic_pkg::FPSIC_SUPPLY_ON_REQUEST: begin
                    if (pin_s.power_good && pin_s.main5v) begin
                        pled = fpsic_pkg::FPSIC_LED_SOLID;
                    end else begin
                        pled = fpsic_pkg::FPSIC_LED_FAST;
                    end
                end
                fpsic_pkg::FPSIC_PS_SLEEP: begin
                    pled = fpsic_pkg::FPSIC_LED_SLOW;
                end
                default: begin
                    pled = fpsic_pkg::FPSIC_LED_OFF;
                end
            endcase
        end
    end

    always_comb begin
        case (pled)
            fpsic_pkg::FPSIC_LED_SOLID: pled_lit = 1'b1;
            fpsic_pkg::FPSIC_LED_SLOW:  pled_lit = slow_ph;
            fpsic_pkg::FPSIC_LED_FAST:  pled_lit = fast_ph;
            default:                    pled_lit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power on self test window
    logic [CW-1:0] power_on_self_test_cnt;             // cycles left in the self test
    logic          power_on_self_test_active;          // drive leds flash while high

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_on_self_test_cnt    <= CW'(POWER_ON_SELF_TEST_LEN - 1);
            power_on_self_test_active <= 1'b1;
        end else if (power_on_self_test_cnt == '0) begin
            power_on_self_test_active <= 1'b0;
        end else begin
            power_on_self_test_cnt <= power_on_self_test_cnt - CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // activity stretch
    // activity pulses are far shorter than a blink, so each one is held
    // until the next low half of fast_ph ends; a drive pulse seen in a low half shows no blink
    logic [ND-1:0] act_hold;             // drive activity seen
    logic          net_hold;             // network activity seen

    for (genvar d = 0; d < ND; d++) begin : g_act
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                act_hold[d] <= 1'b0;
            end else if (pin_s.drive_act[d]) begin
                act_hold[d] <= 1'b1;
            end else if (fast_wrap && !fast_ph) begin
                act_hold[d] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            net_hold <= 1'b0;
        end else if (pin_s.net_act) begin
            net_hold <= 1'b1;
        end else if (fast_wrap && !fast_ph) begin
            net_hold <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // led outputs, all registered and low to light
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_led_n              <= 1'b1;
            system_fault_indicator_n <= 1'b1;
            network_led_n            <= 1'b1;
        end else begin
            power_led_n              <= ~pled_lit;
            system_fault_indicator_n <= ~(supply_fault || fan_fail);
            network_led_n            <= ~(pin_s.net_link && !(net_hold && !fast_ph));
        end
    end

    for (genvar d = 0; d < ND; d++) begin : g_drv
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                drive_fault_led_n[d]    <= 1'b1;
                drive_activity_led_n[d] <= 1'b1;
            end else if (power_on_self_test_active) begin
                drive_fault_led_n[d]    <= ~slow_ph;
                drive_activity_led_n[d] <= ~slow_ph;
            end else begin
                drive_fault_led_n[d]    <= ~drive_fail[d];
                drive_activity_led_n[d] <= ~(act_hold[d] && fast_ph && !drive_fail[d]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request pulses and sticky events
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_request <= 1'b0;
            reset_request <= 1'b0;
        end else begin
            sleep_request <= sw_press[fpsic_pkg::SW_SLEEP];
            reset_request <= sw_press[fpsic_pkg::SW_RESET];
        end
    end

    assign evt_set = {sw_press[fpsic_pkg::SW_NMI], sw_press[fpsic_pkg::SW_POWER],
                      sw_press[fpsic_pkg::SW_RESET], sw_press[fpsic_pkg::SW_SLEEP],
                      power_good_change};

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            events <= '0;
        end else if (wr_event) begin
            events <= (events & ~bus.wdata[fpsic_pkg::EVT_W-1:0]) | evt_set;
        end else begin
            events <= events | evt_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register read side, data one cycle after the strobe
    logic [fpsic_pkg::DATA_W-1:0] next_rdata;  // read mux
    logic [fpsic_pkg::DATA_W-1:0] status_word; // live status

    always_comb begin
        status_word = '0;
        status_word[fpsic_pkg::STAT_LED_LSB +: 2] = pled;
        status_word[fpsic_pkg::STAT_FAULT]        = supply_fault;
        status_word[fpsic_pkg::STAT_MISMATCH]     = mismatch;
        status_word[fpsic_pkg::STAT_PG]           = pin_s.power_good;
        status_word[fpsic_pkg::STAT_STANDBY]      = pin_s.standby;
        status_word[fpsic_pkg::STAT_MAIN5V]       = pin_s.main5v;
        status_word[fpsic_pkg::STAT_POWER_ON_SELF_TEST]         = power_on_self_test_active;
        status_word[fpsic_pkg::STAT_RESET]        = ~system_reset_n;
    end

    // unmapped offsets read as zero
    always_comb begin
        next_rdata = '0;
        case (bus.addr)
            fpsic_pkg::OFS_CTRL: begin
                next_rdata[fpsic_pkg::CTRL_STATE_LSB +: 2] = pstate;
                next_rdata[fpsic_pkg::CTRL_FAN_FAIL]       = fan_fail;
                next_rdata[fpsic_pkg::CTRL_SUPPLY_ON]      = supply_on_request;
            end
            fpsic_pkg::OFS_DRIVE:  next_rdata[ND-1:0] = drive_fail;
            fpsic_pkg::OFS_STATUS: next_rdata = status_word;
            fpsic_pkg::OFS_EVENT:  next_rdata[fpsic_pkg::EVT_W-1:0] = events;
            default:               next_rdata = '0;
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= '0;
        end
    end

endmodule

// >>> fpsic_pkg.sv
// constants and types for the front panel status indicator control block
package fpsic_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_HZ         = 200_000_000;  // system clock rate
    localparam int unsigned SLOW_BLINK_MHZ = 1000;         // slow blink, 1 Hz in millihertz
    localparam int unsigned FAST_BLINK_MHZ = 3300;         // fast blink, 3.3 Hz in millihertz
    localparam int unsigned POWER_ON_SELF_TEST_TIME_MS   = 1000;         // drive led self test flash, 1 s
    localparam int unsigned DEBOUNCE_MS    = 10;           // switch must stay stable this long
    localparam int unsigned PG_WAIT_MS     = 500;          // power good grace after request

    // half periods of the blink patterns, equal on and off halves
    localparam longint SLOW_HALF_CYC = (longint'(CLK_HZ) * 1000) / (2 * SLOW_BLINK_MHZ);
    localparam longint FAST_HALF_CYC = (longint'(CLK_HZ) * 1000) / (2 * FAST_BLINK_MHZ);
    // least times round up to whole cycles
    localparam longint POWER_ON_SELF_TEST_CYC      = (longint'(CLK_HZ) * POWER_ON_SELF_TEST_TIME_MS + 999) / 1000;
    localparam longint DEBOUNCE_CYC  = (longint'(CLK_HZ) * DEBOUNCE_MS + 999) / 1000;
    localparam longint PG_WAIT_CYC   = (longint'(CLK_HZ) * PG_WAIT_MS + 999) / 1000;

    localparam int unsigned CNT_W = 28;                    // holds the largest count above

    ////////////////////////////////////////////////////////////////////////////////
    // register port
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;      // power state, fan, supply request
    localparam logic [ADDR_W-1:0] OFS_DRIVE  = 8'h04;      // per drive failure flags
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;      // read only live state
    localparam logic [ADDR_W-1:0] OFS_EVENT  = 8'h0c;      // sticky events, write one to clear

    // control field positions
    localparam int unsigned CTRL_STATE_LSB = 0;            // two bit system power state
    localparam int unsigned CTRL_FAN_FAIL  = 2;
    localparam int unsigned CTRL_SUPPLY_ON = 3;

    // status field positions
    localparam int unsigned STAT_LED_LSB   = 0;            // two bit power led pattern
    localparam int unsigned STAT_FAULT     = 2;
    localparam int unsigned STAT_MISMATCH  = 3;
    localparam int unsigned STAT_PG        = 4;
    localparam int unsigned STAT_STANDBY   = 5;
    localparam int unsigned STAT_MAIN5V    = 6;
    localparam int unsigned STAT_POWER_ON_SELF_TEST      = 7;
    localparam int unsigned STAT_RESET     = 8;

    // event field positions
    localparam int unsigned EVT_PG_CHANGE  = 0;
    localparam int unsigned EVT_SLEEP      = 1;
    localparam int unsigned EVT_RESET      = 2;
    localparam int unsigned EVT_POWER      = 3;
    localparam int unsigned EVT_NMI        = 4;
    localparam int unsigned EVT_W          = 5;

    localparam int unsigned NUM_DRIVES = 4;
    localparam int unsigned NUM_SW     = 4;

    // switch index within the switch vector
    localparam int unsigned SW_POWER = 0;
    localparam int unsigned SW_SLEEP = 1;
    localparam int unsigned SW_RESET = 2;
    localparam int unsigned SW_NMI   = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        FPSIC_PS_OFF,
        FPSIC_SUPPLY_ON_REQUEST,
        FPSIC_PS_SLEEP,
        FPSIC_PS_RSVD
    } fpsic_pstate_t;

    typedef enum logic [1:0] {
        FPSIC_LED_OFF,
        FPSIC_LED_SOLID,
        FPSIC_LED_SLOW,
        FPSIC_LED_FAST
    } fpsic_led_t;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } fpsic_bus_t;

    // asynchronous board inputs
    typedef struct packed {
        logic                  standby;      // standby supply present
        logic                  main5v;       // main 5 V present
        logic                  power_good;   // supply power good
        logic                  net_link;     // network adapter link present
        logic                  net_act;      // network adapter activity
        logic [NUM_DRIVES-1:0] drive_act;    // drive activity, high while busy
        logic [NUM_SW-1:0]     sw_n;         // switches, low while pressed
    } fpsic_pins_t;

    // open collector switch lines toward the server board
    typedef struct packed {
        logic [NUM_SW-1:0] out;
        logic [NUM_SW-1:0] oe;
    } fpsic_oc_t;

endpackage

// >>> fpsic_top_properties.sv
// port assertions for the front panel status indicator control block
`timescale 1ns/1ps
module fpsic_top_chk (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire fpsic_pkg::fpsic_bus_t  bus,
    input wire fpsic_pkg::fpsic_pins_t pins,
    input wire logic                   supply_on_request,
    input wire logic                   system_reset_n,
    input wire logic                   power_led_n,
    input wire logic                   system_fault_indicator_n,
    input wire fpsic_pkg::fpsic_oc_t   switch_oc,
    input wire logic                   sleep_request,
    input wire logic                   reset_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // open collector lines may only pull low, never drive high
    a_oc_never_high: assert property (switch_oc.out == 4'h0) else $error("oc high");
    a_stby_lost_off: assert property (!pins.standby [*5] |-> power_led_n) else $error("led on");
    // fan writes or an unanswered request are the only fault causes
    a_fault_cause: assert property ($fell(system_fault_indicator_n) |->
        supply_on_request || $past(bus.wr, 2)) else $error("fault cause");
    a_release_clean: assert property ($rose(system_reset_n) |->
        supply_on_request && !$fell(system_fault_indicator_n)) else $error("early release");
    a_release_pg: assert property ($rose(system_reset_n) |->
        $past(pins.power_good, 3)) else $error("release without good");
    a_off_holds: assert property (!supply_on_request [*6] |-> !system_reset_n) else $error("rst");
    a_sleep_once: assert property (sleep_request |=> !sleep_request) else $error("sleep");
    a_reset_once: assert property (reset_request |=> !reset_request) else $error("reset");
    // a press shorter than the debounce span must never reach switch line 3 (NMI)
    a_debounced: assert property ($rose(switch_oc.oe[3]) |->
        !$past(pins.sw_n[3], 3) && !$past(pins.sw_n[3], 4)) else $error("bounce");
    a_req_cause: assert property ($changed(supply_on_request) |->
        $past(bus.wr) || switch_oc.oe[0] || $past(switch_oc.oe[0])) else $error("req");
    c_sleep: cover property (sleep_request);
    c_fault: cover property ($fell(system_fault_indicator_n));
    c_release: cover property ($rose(system_reset_n));
endmodule
bind fpsic_top fpsic_top_chk u_chk (.clk, .rst_n, .bus, .pins, .supply_on_request,
    .system_reset_n, .power_led_n, .system_fault_indicator_n, .switch_oc, .sleep_request,
    .reset_request);

// >>> fpsic_psu_model.sv
// behavioural power supply answering the supply on request
`timescale 1ns/1ps
module fpsic_psu_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic supply_on_request,
    input  wire logic dead,
    output logic      power_good
);
    int cnt;  // cycles since the request was seen
    // good follows the request after a short ramp; a dead supply never answers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            power_good <= 1'b0;
        end else begin
            cnt <= (supply_on_request && !dead) ? cnt + 1 : 0;
            power_good <= supply_on_request && !dead && cnt >= 3;
        end
    end
endmodule

// >>> fpsic_top_tb_top.sv
// self-checking bench for the front panel status indicator control block
`timescale 1ns/1ps
module fpsic_top_tb_top;
    logic                   clk = 0, rst_n = 0, dead = 0, pg, sor, srn, pln, sfn, slr, rsr, nln;
    logic [3:0]             dfl, dal;
    logic [31:0]            rdata, v;
    fpsic_pkg::fpsic_oc_t   oc;
    fpsic_pkg::fpsic_bus_t  b = '0;
    fpsic_pkg::fpsic_pins_t p = 13'h180f;  // standby and 5 V present, switches up
    int                     n_fail = 0, comparisons = 0, cyc = 0, k, np = 0;
    int                     ord[4] = '{1, 2, 3, 0};  // power last, it turns the supply off
    fpsic_top #(.SLOW_HALF(8), .FAST_HALF(4), .POWER_ON_SELF_TEST_LEN(64), .DEB_LEN(4), .PG_WAIT(16)) DUT (
        .clk, .rst_n, .bus(b), .rdata, .pins({p[12:11], pg, p[9:0]}), .supply_on_request(sor),
        .system_reset_n(srn), .power_led_n(pln), .system_fault_indicator_n(sfn),
        .network_led_n(nln), .drive_fault_led_n(dfl), .drive_activity_led_n(dal), .switch_oc(oc),
        .power_good_change(), .sleep_request(slr), .reset_request(rsr));
    fpsic_psu_model PSU (.clk, .rst_n, .supply_on_request(sor), .dead, .power_good(pg));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) np += slr + rsr;
    // a hang ends the run as a failure
    always @(posedge clk) if (++cyc == 5000) begin
        n_fail++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, e, input string nm);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic w(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) b <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) b <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk) b <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk) b <= '0;
        #1 v = rdata;
    endtask
    task automatic lows(int n);
        k = 0;
        repeat (n) @(posedge clk) #1 k += !pln;
    endtask
    task automatic close_out();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h08);
        chk(v[7], 1, "self test");
        w(9);
        chk({dfl, dal}, 8'h00, "drive flash");
        rd(8'h10);
        chk(v, 0, "unmapped");
        $display("power_on_self_test test done");
        wr(8'h00, 32'h9);
        w(12);
        chk(pln, 0, "power led");
        rd(8'h08);
        chk(v[1:0], 1, "pattern");
        wr(8'h00, 32'ha);
        w(2);
        lows(16);
        chk(k, 8, "slow lows");
        wr(8'h00, 32'h9);
        @(posedge clk) dead <= 1'b1;
        w(6);
        lows(8);
        chk(k, 4, "fast lows");
        w(20);
        chk(sfn, 0, "fault led");
        rd(8'h0c);
        chk(v[0], 1, "good event");
        @(posedge clk) dead <= 1'b0;
        w(14);
        chk({sfn, srn}, 2'h3, "fault cleared");
        wr(8'h00, 32'hd);
        w(2);
        chk(sfn, 0, "fan fault");
        wr(8'h00, 32'h9);
        @(posedge clk) p.standby <= 1'b0;
        w(8);
        chk(pln, 1, "standby lost");
        @(posedge clk) p.standby <= 1'b1;
        $display("power test done");
        wr(8'h0c, 32'h1f);
        foreach (ord[j]) begin
            @(posedge clk) p.sw_n[ord[j]] <= 1'b0;
            w(12);
            chk(oc.oe[ord[j]], 1, "switch line");
            @(posedge clk) p.sw_n[ord[j]] <= 1'b1;
            w(12);
        end
        rd(8'h0c);
        chk(v[4:1], 4'hf, "press events");
        chk(sor, 0, "power toggle");
        chk(np, 2, "single pulses");
        $display("switch test done");
        wr(8'h04, 32'h5);
        w(2);
        chk(dfl, 4'ha, "drive fault");
        chk(dal, 4'hf, "drive activity");
        @(posedge clk) p.net_link <= 1'b1;
        w(6);
        chk(nln, 0, "network link");
        @(posedge clk) p.drive_act <= 4'h3;
        w(4);
        k = 0;
        repeat (8) @(posedge clk) #1 k += !dal[1];
        chk(k, 4, "activity blink");
        chk(dal[0], 1, "failed not green");
        $display("drive test done");
        close_out();
    end
endmodule
